/* File: src/mdm_monitor_dac.sv */
// module: demodulator monitor converter with offset removal, gain and sigma-delta output

module mdm_monitor_dac #(
	parameter int SAMPLE_WIDTH = mdm_pkg::SAMPLE_W,
	parameter int BUFFER_DEPTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [mdm_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [SAMPLE_WIDTH-1:0] correlator_sample_i,
	input wire logic [SAMPLE_WIDTH-1:0] linear_sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	output logic demodulator_clock_o,
	output logic recovery_clock_o,
	output logic clock_data_recovery_active_o,
	output logic [mdm_pkg::COEF_W-1:0] loop_integral_coefficient_o,
	output logic [mdm_pkg::COEF_W-1:0] loop_proportional_coefficient_o,
	output logic [mdm_pkg::COEF_W-1:0] pulse_stretch_o,
	output logic monitor_output_pin_o
);
	import mdm_pkg::*;

	localparam int EXT_W = SAMPLE_WIDTH + 9;
	localparam int ACC1_W = SAMPLE_WIDTH + 4;
	localparam int ACC2_W = SAMPLE_WIDTH + 8;

	// =====================================================================
	// declarations
	mdm_bus_state_t bus_state;
	logic [31:0] test_reg;
	mdm_offset_gain_t monitor_offset_gain_reg;
	mdm_clock_ctrl_t clock_ctrl;
	mdm_status_t status;
	logic [31:0] merged_wdata;
	logic [31:0] read_mux;
	logic [DIV_W-1:0] demod_cnt;
	logic [DIV_W-1:0] recovery_cnt;
	logic demod_tick;
	logic recovery_tick;
	logic [TEST_MODE_W-1:0] test_mode;
	logic monitor_enabled;
	logic offset_active;
	logic [SAMPLE_WIDTH-1:0] selected_sample;
	logic [OFFSET_W-1:0] offset_limited;
	logic signed [EXT_W-1:0] difference;
	logic signed [EXT_W-1:0] scaled;
	logic [SAMPLE_WIDTH-1:0] converter_value;
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;
	logic [SAMPLE_WIDTH-1:0] pop_data;
	logic [SAMPLE_WIDTH-1:0] converter_input;
	logic signed [ACC1_W-1:0] acc1;
	logic signed [ACC2_W-1:0] acc2;
	logic signed [ACC1_W-1:0] feedback;
	logic signed [ACC1_W-1:0] next_acc1;
	logic signed [ACC2_W-1:0] next_acc2;
	logic stream_bit;

	// =====================================================================
	// avalon slave: waitrequest drops for exactly one cycle per access
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
		input logic [3:0] enables);
		logic [31:0] result;
		result = old_word;
		for (int i = 0; i < 4; i++) begin
			if (enables[i]) begin
				result[8*i +: 8] = new_word[8*i +: 8];
			end
		end
		return result;
	endfunction

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			bus_state <= BUS_IDLE;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_state <= BUS_ACK;
						avs_waitrequest_o <= 1'b0;
						avs_readdata_o <= avs_read_i ? read_mux : 32'h00000000;
					end
				end
				BUS_ACK: begin
					// one dead cycle lets the master drop its request before a new one is seen
					bus_state <= BUS_DONE;
					avs_waitrequest_o <= 1'b1;
				end
				BUS_DONE: begin
					bus_state <= BUS_IDLE;
				end
				default: begin
					bus_state <= BUS_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		case (avs_address_i)
			TEST_REG_ADDR: read_mux = test_reg;
			CLOCK_CTRL_ADDR: read_mux = clock_ctrl;
			STATUS_ADDR: read_mux = status;
			// offset/gain register is write-only; unmapped addresses read zero
			default: read_mux = 32'h00000000;
		endcase
	end

	assign merged_wdata = merge_bytes(read_mux, avs_writedata_i, avs_byteenable_i);

	// =====================================================================
	// test register: full word, only taken with its own select code
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			test_reg <= TEST_RESET;
		end else if (bus_state == BUS_ACK && avs_write_i && avs_address_i == TEST_REG_ADDR
			&& merged_wdata[3:0] == TEST_SELECT) begin
			test_reg <= merged_wdata;
		end
	end

	// =====================================================================
	// offset and gain register
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			monitor_offset_gain_reg <= '0;
			monitor_offset_gain_reg.register_select <= OFFSET_GAIN_SELECT;
			monitor_offset_gain_reg.loop_integral_coefficient <= INTEGRAL_RESET;
			monitor_offset_gain_reg.loop_proportional_coefficient <= PROPORTIONAL_RESET;
		end else if (bus_state == BUS_ACK && avs_write_i && avs_address_i == OFFSET_GAIN_ADDR
			&& avs_byteenable_i[0] && avs_writedata_i[3:0] == OFFSET_GAIN_SELECT) begin
			// write-only: unwritten byte lanes keep their stored value
			monitor_offset_gain_reg <= merge_bytes(monitor_offset_gain_reg, avs_writedata_i,
				avs_byteenable_i);
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			loop_integral_coefficient_o <= INTEGRAL_RESET;
			loop_proportional_coefficient_o <= PROPORTIONAL_RESET;
			pulse_stretch_o <= '0;
		end else begin
			loop_integral_coefficient_o <= monitor_offset_gain_reg.loop_integral_coefficient;
			loop_proportional_coefficient_o <= monitor_offset_gain_reg.loop_proportional_coefficient;
			pulse_stretch_o <= monitor_offset_gain_reg.pulse_stretch;
		end
	end

	// =====================================================================
	// clock control register
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clock_ctrl <= '0;
			clock_ctrl.demod_div <= DEMOD_DIV_RESET;
			clock_ctrl.recovery_div <= RECOVERY_DIV_RESET;
			clock_ctrl.correlator_select <= CORR_SEL_RESET;
		end else if (bus_state == BUS_ACK && avs_write_i && avs_address_i == CLOCK_CTRL_ADDR) begin
			clock_ctrl <= merged_wdata;
			clock_ctrl.unused <= '0;
		end
	end

	// =====================================================================
	// clock enables: both rates are divided down from the reference clock
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			demod_cnt <= '0;
			demod_tick <= 1'b0;
		end else if (demod_cnt + 1'b1 >= clock_ctrl.demod_div) begin
			demod_cnt <= '0;
			demod_tick <= 1'b1;
		end else begin
			demod_cnt <= demod_cnt + 1'b1;
			demod_tick <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			recovery_cnt <= '0;
			recovery_tick <= 1'b0;
		end else if (recovery_cnt + 1'b1 >= clock_ctrl.recovery_div) begin
			recovery_cnt <= '0;
			recovery_tick <= 1'b1;
		end else begin
			recovery_cnt <= recovery_cnt + 1'b1;
			recovery_tick <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			demodulator_clock_o <= 1'b0;
			recovery_clock_o <= 1'b0;
			clock_data_recovery_active_o <= 1'b1;
		end else begin
			demodulator_clock_o <= demod_tick;
			recovery_clock_o <= recovery_tick;
			// a smaller or equal divider means the recovery rate is not below the demodulator rate
			clock_data_recovery_active_o <= (clock_ctrl.recovery_div > clock_ctrl.demod_div);
		end
	end

	// =====================================================================
	// mode decode: the converter is independent of the rest of the receive setup
	assign test_mode = test_reg[TEST_MODE_LSB +: TEST_MODE_W];
	assign monitor_enabled = (test_mode == MODE_PLAIN) || (test_mode == MODE_OFFSET);
	assign offset_active = (test_mode == MODE_OFFSET);

	// =====================================================================
	// input selection, offset removal and gain
	assign selected_sample = clock_ctrl.correlator_select ? correlator_sample_i : linear_sample_i;

	// offset of 4096 equals full scale of the filter signal
	assign offset_limited = (monitor_offset_gain_reg.offset > OFFSET_LIMIT) ? OFFSET_LIMIT
		: monitor_offset_gain_reg.offset;

	always_comb begin
		difference = EXT_W'($signed(selected_sample));
		if (offset_active) begin
			difference = difference - $signed({{(EXT_W-OFFSET_W-OFFSET_SHIFT){1'b0}}, offset_limited,
				{OFFSET_SHIFT{1'b0}}});
		end
		scaled = difference <<< monitor_offset_gain_reg.gain;
		// saturate rather than wrap: a wrapped value would flip the stream polarity
		if (scaled > $signed(EXT_W'({1'b0, {(SAMPLE_WIDTH-1){1'b1}}}))) begin
			converter_value = {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
		end else if (scaled < -$signed(EXT_W'({1'b1, {(SAMPLE_WIDTH-1){1'b0}}}))) begin
			converter_value = {1'b1, {(SAMPLE_WIDTH-1){1'b0}}};
		end else begin
			converter_value = scaled[SAMPLE_WIDTH-1:0];
		end
	end

	// =====================================================================
	// sample path: taken on the demodulator rate, drained on the recovery rate
	assign push_valid = monitor_enabled && demod_tick && sample_valid_i;
	assign pop_ready = recovery_tick;

	mdm_pair_buffer #(
		.WIDTH(SAMPLE_WIDTH),
		.DEPTH(BUFFER_DEPTH)
	) sample_buffer (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.flush_i(!monitor_enabled),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(converter_value),
		.out_valid_o(pop_valid),
		.out_ready_i(pop_ready),
		.out_data_o(pop_data)
	);

	assign sample_ready_o = push_ready;

	// when no new sample is waiting the last one is repeated
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			converter_input <= '0;
		end else if (!monitor_enabled) begin
			converter_input <= '0;
		end else if (pop_valid && pop_ready) begin
			converter_input <= pop_data;
		end
	end

	// =====================================================================
	// second-order sigma-delta modulator
	// inputs near full scale can overload a second-order loop; use gain with headroom
	assign feedback = stream_bit ? ACC1_W'($signed({1'b0, 1'b1, {(SAMPLE_WIDTH-1){1'b0}}}))
		: -ACC1_W'($signed({1'b0, 1'b1, {(SAMPLE_WIDTH-1){1'b0}}}));
	assign next_acc1 = acc1 + ACC1_W'($signed(converter_input)) - feedback;
	assign next_acc2 = acc2 + ACC2_W'(next_acc1) - ACC2_W'(feedback);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc1 <= '0;
			acc2 <= '0;
			stream_bit <= 1'b0;
		end else if (!monitor_enabled) begin
			acc1 <= '0;
			acc2 <= '0;
			stream_bit <= 1'b0;
		end else if (recovery_tick) begin
			acc1 <= next_acc1;
			acc2 <= next_acc2;
			stream_bit <= !next_acc2[ACC2_W-1];
		end
	end

	// =====================================================================
	// pin driver: one bit per recovery tick, held in between
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			monitor_output_pin_o <= 1'b0;
		end else begin
			monitor_output_pin_o <= monitor_enabled && stream_bit;
		end
	end

	// =====================================================================
	// status word
	always_comb begin
		status = '0;
		status.monitor_enabled = monitor_enabled;
		status.offset_active = offset_active;
		status.recovery_blocked = !clock_data_recovery_active_o;
		status.buffer_full = !push_ready;
		status.converter_input = converter_input;
	end

endmodule

/* File: src/mdm_pkg.sv */
// package: register map, field layouts and reset values of the demodulator monitor converter
package mdm_pkg;

	// =====================================================================
	// widths
	localparam int SAMPLE_W = 16;
	localparam int ADDR_W = 4;
	localparam int DIV_W = 8;
	localparam int OFFSET_W = 13;
	localparam int GAIN_W = 3;
	localparam int COEF_W = 4;

	// =====================================================================
	// register byte offsets on the avalon slave
	localparam logic [ADDR_W-1:0] TEST_REG_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] OFFSET_GAIN_ADDR = 4'h4;
	localparam logic [ADDR_W-1:0] CLOCK_CTRL_ADDR = 4'h8;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'hc;

	// =====================================================================
	// test register layout
	localparam int TEST_MODE_LSB = 14;
	localparam int TEST_MODE_W = 4;
	localparam logic [3:0] TEST_SELECT = 4'hc;
	localparam logic [3:0] OFFSET_GAIN_SELECT = 4'hd;
	localparam logic [TEST_MODE_W-1:0] MODE_PLAIN = 4'h7;
	localparam logic [TEST_MODE_W-1:0] MODE_OFFSET = 4'ha;
	localparam logic [31:0] TEST_RESET = 32'h0000000c;

	// =====================================================================
	// offset and gain register layout
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic [OFFSET_W-1:0] offset;
		logic [COEF_W-1:0] pulse_stretch;
		logic [COEF_W-1:0] loop_integral_coefficient;
		logic [COEF_W-1:0] loop_proportional_coefficient;
		logic [3:0] register_select;
	} mdm_offset_gain_t;

	localparam logic [COEF_W-1:0] INTEGRAL_RESET = 4'h3;
	localparam logic [COEF_W-1:0] PROPORTIONAL_RESET = 4'h2;
	localparam logic [OFFSET_W-1:0] OFFSET_LIMIT = 13'h1000;
	localparam int OFFSET_SHIFT = 3;

	// =====================================================================
	// clock control register layout
	typedef struct packed {
		logic [14:0] unused;
		logic correlator_select;
		logic [DIV_W-1:0] recovery_div;
		logic [DIV_W-1:0] demod_div;
	} mdm_clock_ctrl_t;

	localparam logic [DIV_W-1:0] DEMOD_DIV_RESET = 8'h02;
	localparam logic [DIV_W-1:0] RECOVERY_DIV_RESET = 8'h04;
	localparam logic CORR_SEL_RESET = 1'b1;

	// =====================================================================
	// status register layout
	typedef struct packed {
		logic [SAMPLE_W-1:0] converter_input;
		logic [11:0] unused;
		logic buffer_full;
		logic recovery_blocked;
		logic offset_active;
		logic monitor_enabled;
	} mdm_status_t;

	// =====================================================================
	// avalon slave bus states
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_ACK = 3'b010,
		BUS_DONE = 3'b100
	} mdm_bus_state_t;

endpackage

/* File: src/mdm_pair_buffer.sv */
// module: two-entry buffer with valid and ready on both sides
module mdm_pair_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;
	logic push;
	logic pop;
	logic [PTR_W:0] next_count;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
	assign out_data_o = store[rd_ptr];

	// =====================================================================
	// pointers and fill level
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else if (flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= next_count;
			// ready is registered so the source sees a clean level
			in_ready_o <= (next_count != (PTR_W+1)'(DEPTH));
			out_valid_o <= (next_count != '0);
		end
	end

	// =====================================================================
	// storage
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			store[wr_ptr] <= in_data_i;
		end
	end

endmodule

/* File: tb/mdm_monitor_dac_props.sv */
// checker: concurrent properties on the monitor converter ports
module mdm_monitor_dac_props
	import mdm_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [mdm_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic recovery_clock_o,
	input wire logic clock_data_recovery_active_o,
	input wire logic [mdm_pkg::COEF_W-1:0] loop_integral_coefficient_o,
	input wire logic [mdm_pkg::COEF_W-1:0] loop_proportional_coefficient_o,
	input wire logic monitor_output_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// =====================================================================
	// properties
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	AST_ACK_CAUSE: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
		else $error("acknowledge without request");
	AST_ACK_BOUND: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|-> ##[1:4] !avs_waitrequest_o)
		else $error("request not acknowledged in time");
	AST_WRITE_ZERO: assert property ($fell(avs_waitrequest_o) && $past(avs_write_i)
		|-> avs_readdata_o == 32'h0)
		else $error("read data not zero after write");
	AST_WO_READ: assert property ($fell(avs_waitrequest_o) && $past(avs_address_i) == OFFSET_GAIN_ADDR
		|-> avs_readdata_o == 32'h0)
		else $error("write-only register returned data");
	// a rising bit must follow a recovery tick; falls may also come from disabling
	AST_PIN_TICK: assert property ($rose(monitor_output_pin_o)
		|-> $past(recovery_clock_o) || $past(recovery_clock_o, 2))
		else $error("pin rose away from a recovery tick");
	AST_RECOVERY_CAUSE: assert property ($changed(clock_data_recovery_active_o)
		|-> $past(!avs_waitrequest_o) || $past(!avs_waitrequest_o, 2))
		else $error("recovery state changed without a write");
	AST_COEF_CAUSE: assert property ($changed({loop_integral_coefficient_o, loop_proportional_coefficient_o})
		|-> $past(!avs_waitrequest_o) || $past(!avs_waitrequest_o, 2))
		else $error("coefficients changed without a write");
	cover property ($rose(monitor_output_pin_o));
	cover property ($fell(clock_data_recovery_active_o));
	cover property ($fell(avs_waitrequest_o) && $past(avs_write_i));
endmodule

/* File: tb/mdm_rc_filter.sv */
// partner: external rc filter, modelled as a ones count over fixed windows
module mdm_rc_filter (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic monitor_output_pin_i,
	output logic [16:0] level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] tick_count;
	logic [10:0] ones;
	// =====================================================================
	// averaging: 1024-cycle window, scaled to offset-binary 0..65536
	// trade-off: a box average settles in one window, unlike a real rc pole
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tick_count <= 10'h0;
			ones <= 11'h0;
			level_o <= 17'h0;
		end else begin
			tick_count <= tick_count + 10'h1;
			if (tick_count == 10'h3ff) begin
				level_o <= {ones + 11'(monitor_output_pin_i), 6'h0};
				ones <= 11'h0;
			end else begin
				ones <= ones + 11'(monitor_output_pin_i);
			end
		end
	end
endmodule

/* File: tb/demod_monitor_sigma_delta_dac_tb.sv */
// testbench: register bus, sample stream and bit stream of the monitor converter
module demod_monitor_sigma_delta_dac_tb
	import mdm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic [15:0] corr = 16'h0;
	logic [15:0] lin = 16'h0;
	logic valid = 1'b0;
	logic [31:0] rdata;
	logic wait_req, s_ready, demod_pulse, rec_clk, recovery_on, pin;
	logic [3:0] integ, prop, stretch;
	logic [16:0] level;
	logic [31:0] q;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	int m;

	always #25 ref_clk_i = ~ref_clk_i;

	mdm_monitor_dac dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_req), .correlator_sample_i(corr), .linear_sample_i(lin),
		.sample_valid_i(valid), .sample_ready_o(s_ready), .demodulator_clock_o(demod_pulse),
		.recovery_clock_o(rec_clk), .clock_data_recovery_active_o(recovery_on),
		.loop_integral_coefficient_o(integ), .loop_proportional_coefficient_o(prop),
		.pulse_stretch_o(stretch), .monitor_output_pin_o(pin));
	mdm_rc_filter rc (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .monitor_output_pin_i(pin), .level_o(level));

	// =====================================================================
	// checking and closing
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// =====================================================================
	// avalon master: hold until waitrequest is seen low, then release
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		rd <= ~w;
		wr <= w;
		k = 0;
		// waitrequest and read data are taken at the rising edge, before the slave updates them
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (wait_req !== 1'b0 && k < 100);
		if (wait_req !== 1'b0) begin
			fail_count++;
			report_and_stop();
		end
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task settle;
		repeat (2) @(negedge ref_clk_i);
	endtask

	// =====================================================================
	// expectation: (signal - offset*8) * 2^gain, saturated
	function automatic logic [15:0] conv(input logic [15:0] s, input logic [12:0] off, input logic [2:0] g,
		input logic use_off);
		logic signed [31:0] v;
		v = 32'(signed'(s));
		if (use_off) v = v - (32'(off > OFFSET_LIMIT ? OFFSET_LIMIT : off) << OFFSET_SHIFT);
		v = v <<< g;
		if (v > 32767) v = 32767;
		else if (v < -32768) v = -32768;
		return v[15:0];
	endfunction

	task run_case(input logic [15:0] s, input logic [2:0] g, input logic [12:0] off, input logic use_off,
		input logic sel, input logic tol);
		logic [15:0] e;
		int diff;
		bus(1'b1, CLOCK_CTRL_ADDR, {15'h0, sel, 8'h04, 8'h02}, q);
		corr <= sel ? s : 16'($urandom);
		lin <= sel ? 16'($urandom) : s;
		bus(1'b1, OFFSET_GAIN_ADDR, {g, off, 4'h0, 4'h3, 4'h2, 4'hd}, q);
		repeat (2200) @(posedge ref_clk_i);
		e = conv(s, off, g, use_off);
		bus(1'b0, STATUS_ADDR, 32'h0, q);
		check(q[31:16], e);
		if (tol) begin
			diff = int'(level) - (int'(signed'(e)) + 32768);
			check(diff < 2048 && diff > -2048, 1'b1);
		end
		$display("case done: sample=%h gain=%0d expect=%h", s, g, e);
	endtask

	// =====================================================================
	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		void'($urandom(32'he7f7));
		settle();
		check(integ, INTEGRAL_RESET);
		check(prop, PROPORTIONAL_RESET);
		check(stretch, 4'h0);
		check(pin, 1'b0);
		bus(1'b0, TEST_REG_ADDR, 32'h0, q);
		check(q, TEST_RESET);
		bus(1'b0, OFFSET_GAIN_ADDR, 32'h0, q);
		check(q, 32'h0);
		bus(1'b0, 4'h2, 32'h0, q);
		check(q, 32'h0);
		$display("test done: reset values");
		valid <= 1'b1;
		bus(1'b1, TEST_REG_ADDR, 32'h0001c00c, q);
		bus(1'b0, STATUS_ADDR, 32'h0, q);
		check(q[1:0], 2'b01);
		for (int i = 0; i < 4; i++) begin
			run_case(16'($urandom_range(8000)) - 16'h0fa0, 3'($urandom_range(2)), 13'($urandom), 1'b0, 1'b1, 1'b1);
		end
		run_case(16'h7fff, 3'h7, 13'h0, 1'b0, 1'b1, 1'b0);
		// recovery ticks every 4 cycles, demodulator ticks every 2
		// a full buffer frees one slot per recovery tick, so ready is high a quarter or half of the time
		n = 0;
		m = 0;
		for (int i = 0; i < 400; i++) begin
			@(negedge ref_clk_i);
			n += 2 * int'(rec_clk) + 32 * int'(demod_pulse);
			m += int'(s_ready === 1'b1);
		end
		check(n, 32'd6600);
		check(m > 90 && m < 210, 1'b1);
		bus(1'b1, OFFSET_GAIN_ADDR, {3'h0, 13'h0, 4'ha, 4'h5, 4'h9, 4'hd}, q);
		settle();
		check({integ, prop, stretch}, 12'h59a);
		bus(1'b1, OFFSET_GAIN_ADDR, {3'h0, 13'h0, 4'h1, 4'h1, 4'h1, 4'hc}, q);
		be <= 4'he;
		settle();
		check({integ, prop, stretch}, 12'h59a);
		// without the select byte lane the word must be refused
		bus(1'b1, OFFSET_GAIN_ADDR, {3'h0, 13'h0, 4'h1, 4'h1, 4'h1, 4'hd}, q);
		be <= 4'hf;
		settle();
		check({integ, prop, stretch}, 12'h59a);
		$display("test done: coefficients");
		bus(1'b1, TEST_REG_ADDR, 32'h0002800c, q);
		bus(1'b0, STATUS_ADDR, 32'h0, q);
		check(q[1:0], 2'b11);
		for (int i = 0; i < 3; i++) begin
			run_case(16'($urandom_range(8000)) - 16'h0fa0, 3'h0, 13'($urandom_range(1500)), 1'b1, 1'b0,
				1'b1);
		end
		run_case(16'h7fff, 3'h0, 13'h1fff, 1'b1, 1'b0, 1'b0);
		bus(1'b1, CLOCK_CTRL_ADDR, {15'h0, 1'b1, 8'h02, 8'h02}, q);
		settle();
		check(recovery_on, 1'b0);
		bus(1'b0, STATUS_ADDR, 32'h0, q);
		check(q[2], 1'b1);
		bus(1'b1, CLOCK_CTRL_ADDR, {15'h0, 1'b1, 8'h04, 8'h02}, q);
		settle();
		check(recovery_on, 1'b1);
		$display("test done: recovery clock");
		bus(1'b1, TEST_REG_ADDR, TEST_RESET, q);
		repeat (20) @(posedge ref_clk_i);
		n = 0;
		for (int i = 0; i < 200; i++) begin
			@(negedge ref_clk_i);
			n += int'(pin !== 1'b0);
		end
		check(n, 32'd0);
		check(s_ready, 1'b1);
		$display("test done: disable");
		report_and_stop();
	end
endmodule

bind mdm_monitor_dac mdm_monitor_dac_props props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .recovery_clock_o(recovery_clock_o),
	.clock_data_recovery_active_o(clock_data_recovery_active_o),
	.loop_integral_coefficient_o(loop_integral_coefficient_o),
	.loop_proportional_coefficient_o(loop_proportional_coefficient_o),
	.monitor_output_pin_o(monitor_output_pin_o));
